// file: include/rxm_pkg.sv
// constants and carrier types of the receive measurement block
package rxm_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CAL_TIME_NS   = 10000;
    localparam int CAL_CYC       = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int THERM_TIME_NS = 100000;
    localparam int THERM_CYC     = (THERM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AVG_DEPTH     = 256;
    localparam int FIR_TAPS      = 16;

    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_LVLCFG = 12'h004;
    localparam logic [11:0] ADDR_FILT   = 12'h008;
    localparam logic [11:0] ADDR_FDIV   = 12'h00c;
    localparam logic [11:0] ADDR_DETTH  = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;
    localparam logic [11:0] ADDR_LEVEL  = 12'h018;
    localparam logic [11:0] ADDR_LIVE   = 12'h01c;
    localparam logic [11:0] ADDR_FRAME  = 12'h020;
    localparam logic [11:0] ADDR_THERM  = 12'h024;
    localparam logic [11:0] ADDR_LIMA   = 12'h028;
    localparam logic [11:0] ADDR_LIMB   = 12'h02c;

    typedef enum logic [2:0] {
        RXM_SLEEP   = 3'b000,
        RXM_STANDBY = 3'b001,
        RXM_SYNTX   = 3'b010,
        RXM_TX      = 3'b011,
        RXM_SYNRX   = 3'b100,
        RXM_RX      = 3'b101
    } rxm_opmode_t;

    typedef struct packed {
        logic [2:0] op_mode;
        logic       spread_mode;
        logic       cal_start;
        logic       thermal_sensor_disable;
    } rxm_ctrl_t;

    typedef struct packed {
        logic signed [4:0] signal_level_compensation;
        logic [2:0]        signal_average_select;
    } rxm_lvlcfg_t;

    typedef struct packed {
        logic [1:0] filter_width_mantissa;
        logic [2:0] filter_width_exponent;
    } rxm_filt_t;

    typedef struct packed {
        logic signed [7:0] lim5;
        logic signed [7:0] lim4;
        logic signed [7:0] lim3;
        logic signed [7:0] lim2;
        logic signed [7:0] gain_step_limit_one;
    } rxm_lim_t;

    localparam rxm_ctrl_t   CTRL_RST   = 6'h08;
    localparam rxm_lvlcfg_t LVLCFG_RST = 8'h02;
    localparam rxm_filt_t   FILT_RST   = 5'h15;
    localparam logic [7:0]  DETTH_RST  = 8'hff;
    localparam rxm_lim_t    LIM_RST    = 40'hce_c4_ba_b0_a6;
    localparam logic signed [7:0] CAL_REF_LEVEL = 8'hc4;

    localparam logic [2:0] GAIN_G1 = 3'b001;
    localparam logic [2:0] GAIN_G2 = 3'b010;
    localparam logic [2:0] GAIN_G3 = 3'b011;
    localparam logic [2:0] GAIN_G4 = 3'b100;
    localparam logic [2:0] GAIN_G5 = 3'b110;
    localparam logic [2:0] GAIN_G6 = 3'b111;

    localparam logic signed [7:0] FIR_COEF [FIR_TAPS] = '{
        8'hfe, 8'hfd, 8'h00, 8'h08, 8'h14, 8'h23, 8'h30, 8'h38,
        8'h38, 8'h30, 8'h23, 8'h14, 8'h08, 8'h00, 8'hfd, 8'hfe};
endpackage

// file: design/rxm_avg_mem.sv
// sample history memory with registered read-first output
`timescale 1ns/100ps
`default_nettype none
module rxm_avg_mem #(
    parameter int W     = 8,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata_q
);
    logic [W-1:0] mem [DEPTH];

    if (DEPTH != (1 << AW)) begin : g_chk
        $error("depth must be two to the address width");
    end

    always_ff @(posedge clk) begin
        rdata_q <= mem[raddr];
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule
`default_nettype wire

// file: design/rxm_fir16.sv
// sixteen tap channel filter
`timescale 1ns/100ps
`default_nettype none
module rxm_fir16
    import rxm_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                in_valid,
    input  wire logic signed [W-1:0] in_data,
    output logic                     out_valid_q,
    output logic signed [W-1:0]      out_data_q
);
    localparam int SW = W + 12;
    logic signed [W-1:0] tap_q [FIR_TAPS];
    logic signed [SW-1:0] acc;

    if (W < 2) begin : g_chk
        $error("filter width too small");
    end

    always_comb begin
        acc = '0;
        for (int i = 0; i < FIR_TAPS; i++) begin
            acc = acc + SW'(tap_q[i] * FIR_COEF[i]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < FIR_TAPS; i++) tap_q[i] <= '0;
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else begin
            out_valid_q <= in_valid;
            if (in_valid) begin
                tap_q[0] <= in_data;
                for (int i = 1; i < FIR_TAPS; i++) tap_q[i] <= tap_q[i-1];
                out_data_q <= acc[W+7:8];
            end
        end
    end
endmodule
`default_nettype wire

// file: design/rxm_top.sv
// receive signal strength, gain step, filter and thermal measurement block
`timescale 1ns/100ps
`default_nettype none
module rxm_top
    import rxm_pkg::*;
#(
    parameter int THERM_CONV = THERM_CYC,
    parameter int CAL_LEN    = CAL_CYC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [11:0]        paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic signed [7:0]  level_in,
    input  wire logic               level_valid,
    input  wire logic signed [7:0]  bb_sample,
    input  wire logic               bb_valid,
    input  wire logic               preamble_ok,
    input  wire logic               header_ok_event,
    input  wire logic               receive_complete_event,
    input  wire logic [7:0]         ss_level,
    input  wire logic               ss_valid,
    input  wire logic [7:0]         therm_adc,
    output logic                    rx_active,
    output logic signed [7:0]       rx_data,
    output logic                    rx_data_valid,
    output logic [2:0]              front_gain_step,
    output logic                    sensor_enable,
    output logic                    cal_busy
);
    import rxm_pkg::*;

    typedef enum logic [1:0] {
        RXM_IDLE = 2'b00,
        RXM_ENAB = 2'b01,
        RXM_ACT  = 2'b10
    } rxm_rxst_t;

    if (THERM_CONV < 1 || CAL_LEN < 1 || CAL_LEN > 65535 || THERM_CONV > 65535) begin : g_chk
        $error("timing counts out of range");
    end

    function automatic logic [8:0] avg_len(input logic [2:0] sel);
        avg_len = 9'h002 << sel;
    endfunction

    function automatic logic signed [7:0] sat8(input logic signed [9:0] v);
        if (v > 10'sd127) sat8 = 8'h7f;
        else if (v < -10'sd128) sat8 = 8'h80;
        else sat8 = v[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers and apb

    rxm_ctrl_t   ctrl_q;
    rxm_lvlcfg_t lvlcfg_q;
    rxm_filt_t   filt_q;
    rxm_lim_t    lim_q;
    logic [7:0]  detth_q;
    logic [7:0]  level_rd_q;
    logic        level_ok_q;
    logic [7:0]  live_q;
    logic [7:0]  frame_q;
    logic [7:0]  therm_q;
    rxm_rxst_t   rxst_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] rd_mux;
    logic        hit;
    logic [15:0] fdiv;

    wire setup_rd = psel & ~penable;
    wire wr_ok    = psel & penable & pready_q & pwrite;
    wire wr_ctrl  = wr_ok & (paddr == ADDR_CTRL);

    // reserved mantissa or exponent zero gives divisor zero
    assign fdiv = (filt_q.filter_width_mantissa == 2'b11 || filt_q.filter_width_exponent == 3'h0) ? 16'h0000 :
                  (16'h0010 + {12'h000, filt_q.filter_width_mantissa, 2'b00}) <<
                  ({1'b0, filt_q.filter_width_exponent} + 4'h2);

    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL:   rd_mux = {26'h0, ctrl_q.op_mode, ctrl_q.spread_mode, 1'b0, ctrl_q.thermal_sensor_disable};
            ADDR_LVLCFG: rd_mux = {24'h0, lvlcfg_q};
            ADDR_FILT:   rd_mux = {27'h0, filt_q};
            ADDR_FDIV:   rd_mux = {16'h0, fdiv};
            ADDR_DETTH:  rd_mux = {24'h0, detth_q};
            ADDR_STATUS: rd_mux = {26'h0, level_ok_q, front_gain_step, cal_busy, rx_active};
            ADDR_LEVEL:  rd_mux = {24'h0, level_rd_q};
            ADDR_LIVE:   rd_mux = {24'h0, live_q};
            ADDR_FRAME:  rd_mux = {24'h0, frame_q};
            ADDR_THERM:  rd_mux = {24'h0, therm_q};
            ADDR_LIMA:   rd_mux = lim_q[31:0];
            ADDR_LIMB:   rd_mux = {24'h0, lim_q[39:32]};
            default:     hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup_rd;
            pslverr_q <= setup_rd & ~hit;
            if (setup_rd) prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= CTRL_RST;
            lvlcfg_q <= LVLCFG_RST;
            filt_q   <= FILT_RST;
            detth_q  <= DETTH_RST;
            lim_q    <= LIM_RST;
        end else begin
            ctrl_q.cal_start <= 1'b0;
            if (wr_ctrl) ctrl_q <= pwdata[5:0];
            if (wr_ok && paddr == ADDR_LVLCFG) lvlcfg_q <= pwdata[7:0];
            if (wr_ok && paddr == ADDR_FILT) filt_q <= pwdata[4:0];
            if (wr_ok && paddr == ADDR_DETTH) detth_q <= pwdata[7:0];
            if (wr_ok && paddr == ADDR_LIMA) lim_q[31:0] <= pwdata;
            if (wr_ok && paddr == ADDR_LIMB) lim_q[39:32] <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // calibration and gain step

    logic [15:0]       cal_cnt_q;
    logic signed [7:0] bias_q;
    logic signed [7:0] lvl_c;
    logic [2:0]        step;

    assign lvl_c = sat8(10'(level_in) + 10'(bias_q));
    assign step  = (lvl_c <= lim_q.gain_step_limit_one) ? GAIN_G1 :
                   (lvl_c <= lim_q.lim2) ? GAIN_G2 :
                   (lvl_c <= lim_q.lim3) ? GAIN_G3 :
                   (lvl_c <= lim_q.lim4) ? GAIN_G4 :
                   (lvl_c <= lim_q.lim5) ? GAIN_G5 : GAIN_G6;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt_q       <= 16'h0000;
            cal_busy        <= 1'b0;
            bias_q          <= 8'h00;
            front_gain_step <= GAIN_G1;
        end else begin
            if (ctrl_q.cal_start && !cal_busy) begin
                cal_busy  <= 1'b1;
                cal_cnt_q <= 16'(CAL_LEN - 1);
            end else if (cal_busy) begin
                if (cal_cnt_q == 16'h0000) begin
                    cal_busy <= 1'b0;
                    bias_q   <= sat8(10'(CAL_REF_LEVEL) - 10'(level_in));
                end else begin
                    cal_cnt_q <= cal_cnt_q - 16'h0001;
                end
            end
            if (level_valid && !cal_busy) front_gain_step <= step;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // moving average of the level

    logic [7:0]         wr_ptr_q;
    logic [8:0]         filled_q;
    logic [2:0]         sel_prev_q;
    logic               s1_v_q;
    logic               s1_full_q;
    logic signed [7:0]  s1_new_q;
    logic signed [16:0] sum_q;
    logic [7:0]         old_raw;
    logic signed [16:0] sum_d;
    logic signed [16:0] avg;
    logic signed [11:0] rd_val;

    wire [8:0] win    = avg_len(lvlcfg_q.signal_average_select);
    wire       lvl_v  = level_valid & ~cal_busy;
    wire       restart = cal_busy | (sel_prev_q != lvlcfg_q.signal_average_select);

    rxm_avg_mem #(.W(8), .DEPTH(AVG_DEPTH), .AW(8)) u_mem (
        .clk     (pclk),
        .we      (lvl_v),
        .waddr   (wr_ptr_q),
        .wdata   (lvl_c),
        .raddr   (wr_ptr_q - win[7:0]),
        .rdata_q (old_raw)
    );

    assign sum_d  = sum_q + 17'(s1_new_q) - (s1_full_q ? 17'(signed'(old_raw)) : 17'sd0);
    assign avg    = sum_d >>> ({1'b0, lvlcfg_q.signal_average_select} + 4'h1);
    assign rd_val = 12'(-(avg <<< 1)) + 12'(lvlcfg_q.signal_level_compensation);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q   <= 8'h00;
            filled_q   <= 9'h000;
            sel_prev_q <= LVLCFG_RST.signal_average_select;
            s1_v_q     <= 1'b0;
            s1_full_q  <= 1'b0;
            s1_new_q   <= 8'h00;
            sum_q      <= 17'h00000;
            level_rd_q <= 8'h00;
            level_ok_q <= 1'b0;
        end else begin
            sel_prev_q <= lvlcfg_q.signal_average_select;
            s1_v_q     <= lvl_v & ~restart;
            if (restart) begin
                filled_q   <= 9'h000;
                sum_q      <= 17'h00000;
                level_ok_q <= 1'b0;
            end else begin
                if (lvl_v) begin
                    wr_ptr_q  <= wr_ptr_q + 8'h01;
                    s1_new_q  <= lvl_c;
                    s1_full_q <= (filled_q >= win);
                    if (filled_q < win) filled_q <= filled_q + 9'h001;
                end
                if (s1_v_q) begin
                    sum_q <= sum_d;
                    if (s1_full_q || filled_q >= win) begin
                        level_ok_q <= 1'b1;
                        level_rd_q <= (rd_val < 12'sd0) ? 8'h00 :
                                      (rd_val > 12'sd255) ? 8'hff : rd_val[7:0];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive states and channel filter

    logic              fir_v;
    logic signed [7:0] fir_d;

    rxm_fir16 #(.W(8)) u_fir (
        .pclk        (pclk),
        .presetn     (presetn),
        .in_valid    (bb_valid),
        .in_data     (bb_sample),
        .out_valid_q (fir_v),
        .out_data_q  (fir_d)
    );

    wire in_rx  = (ctrl_q.op_mode == RXM_RX);
    wire detect = preamble_ok | (level_ok_q & (level_rd_q <= detth_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxst_q        <= RXM_IDLE;
            rx_active     <= 1'b0;
            rx_data       <= 8'h00;
            rx_data_valid <= 1'b0;
        end else begin
            case (rxst_q)
                RXM_IDLE: if (in_rx) rxst_q <= RXM_ENAB;
                RXM_ENAB: begin
                    if (!in_rx) rxst_q <= RXM_IDLE;
                    else if (detect) rxst_q <= RXM_ACT;
                end
                RXM_ACT: begin
                    if (!in_rx) rxst_q <= RXM_IDLE;
                    else if (receive_complete_event) rxst_q <= RXM_ENAB;
                end
                default: rxst_q <= RXM_IDLE;
            endcase
            rx_active     <= (rxst_q == RXM_ACT);
            rx_data_valid <= (rxst_q == RXM_ACT) & fir_v;
            if (fir_v) rx_data <= fir_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // spread-spectrum live and frame values

    logic [10:0] frm_acc_q;
    logic        in_frame_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_q     <= 8'h00;
            frame_q    <= 8'h00;
            frm_acc_q  <= 11'h000;
            in_frame_q <= 1'b0;
        end else begin
            if (ss_valid) live_q <= ss_level;
            if (ctrl_q.spread_mode && ss_valid) begin
                frm_acc_q <= frm_acc_q - {3'h0, frm_acc_q[10:3]} + {3'h0, ss_level};
            end
            if (ctrl_q.spread_mode && receive_complete_event && in_frame_q) begin
                frame_q    <= frm_acc_q[10:3];
                in_frame_q <= 1'b0;
            end
            if (header_ok_event) in_frame_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // thermal sensor

    logic [7:0]  th_s1_q;
    logic [7:0]  th_s2_q;
    logic [15:0] th_cnt_q;

    wire th_run = ~ctrl_q.thermal_sensor_disable & (ctrl_q.op_mode != RXM_SLEEP) &
                  (ctrl_q.op_mode != RXM_STANDBY);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            th_s1_q       <= 8'h00;
            th_s2_q       <= 8'h00;
            th_cnt_q      <= 16'h0000;
            therm_q       <= 8'h00;
            sensor_enable <= 1'b0;
        end else begin
            th_s1_q       <= therm_adc;
            th_s2_q       <= th_s1_q;
            sensor_enable <= th_run;
            if (!th_run) begin
                th_cnt_q <= 16'h0000;
            end else if (th_cnt_q == 16'(THERM_CONV - 1)) begin
                th_cnt_q <= 16'h0000;
                therm_q  <= th_s2_q;
            end else begin
                th_cnt_q <= th_cnt_q + 16'h0001;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
endmodule
`default_nettype wire

// file: test/rxm_properties.sv
// port checker of the receive measurement block
`timescale 1ns/100ps
`default_nettype none
module rxm_properties #(
    parameter int CAL_LEN = 5
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        level_valid,
    input wire logic        bb_valid,
    input wire logic        rx_data_valid,
    input wire logic [2:0]  front_gain_step,
    input wire logic        cal_busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] cal_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt_q <= 16'h0;
        end else begin
            cal_cnt_q <= cal_busy ? cal_cnt_q + 16'h1 : 16'h0;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    a_ready_one: assert property (s_setup |=> pready && psel && penable)
        else $error("no ready after setup");
    a_ready_only: assert property (!(psel && !penable) |=> !pready)
        else $error("ready without setup");
    a_err_map: assert property (pready && paddr > 12'h02c |-> pslverr)
        else $error("unmapped without error");
    a_rdata_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read not zero");
    a_gain_code: assert property (front_gain_step inside {3'b001, 3'b010, 3'b011, 3'b100, 3'b110, 3'b111})
        else $error("illegal gain code");
    a_gain_hold: assert property (!level_valid |=> $stable(front_gain_step))
        else $error("gain moved without sample");
    a_gain_cal: assert property (cal_busy && level_valid |=> $stable(front_gain_step))
        else $error("gain moved in calibration");
    a_data_valid: assert property (rx_data_valid |-> $past(bb_valid, 2))
        else $error("filter output without input");
    a_cal_len: assert property ($fell(cal_busy) |-> cal_cnt_q == 16'(CAL_LEN))
        else $error("calibration length wrong");
endmodule
bind rxm_top rxm_properties #(.CAL_LEN(CAL_LEN)) u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .level_valid(level_valid), .bb_valid(bb_valid), .rx_data_valid(rx_data_valid),
    .front_gain_step(front_gain_step), .cal_busy(cal_busy));
`default_nettype wire

// file: test/rxm_host_model.sv
// register bus host model
`timescale 1ns/100ps
`default_nettype none
module rxm_host_model (
    input  wire logic        pclk,
    output logic      [11:0] paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // one transfer, called just after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// file: test/rx_signal_strength_and_temp_bench.sv
// scenarios of the receive measurement block
`timescale 1ns/100ps
`default_nettype none
module rx_signal_strength_and_temp_bench;
    import rxm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [7:0] level_in, bb_sample, rx_data;
    logic level_valid, bb_valid, preamble_ok, hdr_ev, done_ev, ss_valid;
    logic [7:0] ss_level, therm_adc;
    logic rx_active, rx_data_valid, sensor_enable, cal_busy;
    logic [2:0] front_gain_step;
    int bad_count = 0;
    int num_checks = 0;
    int acc;

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    rxm_host_model u_host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rxm_top #(.THERM_CONV(20), .CAL_LEN(5)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .level_in(level_in), .level_valid(level_valid),
        .bb_sample(bb_sample), .bb_valid(bb_valid), .preamble_ok(preamble_ok), .header_ok_event(hdr_ev),
        .receive_complete_event(done_ev), .ss_level(ss_level), .ss_valid(ss_valid), .therm_adc(therm_adc),
        .rx_active(rx_active), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
        .front_gain_step(front_gain_step), .sensor_enable(sensor_enable), .cal_busy(cal_busy));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        u_host.xfer(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, er);
    endtask
    task lvl(input logic signed [7:0] v);
        level_in <= v;
        level_valid <= 1'b1;
        @(posedge pclk);
        level_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task pulse_ss(input logic [7:0] v);
        ss_level <= v;
        ss_valid <= 1'b1;
        @(posedge pclk);
        ss_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk({sensor_enable, front_gain_step}, 4'h1);
        rdc(ADDR_CTRL, 32'h8);
        rdc(ADDR_LVLCFG, 32'h2);
        rdc(ADDR_FILT, 32'h15);
        rdc(ADDR_FDIV, 32'hc00);
        rdc(ADDR_LIMA, 32'hc4bab0a6);
        rdc(12'h030, 32'h0);
        chk(er, 1'b1);
        $display("reset test done");
    endtask
    task t_filt;
        logic [4:0] f [5] = '{5'h01, 5'h0f, 5'h14, 5'h1a, 5'h00};
        logic [31:0] e [5] = '{32'h80, 32'h2800, 32'h600, 32'h0, 32'h0};
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_FILT, {27'h0, f[i]});
            rdc(ADDR_FDIV, e[i]);
        end
        $display("filter test done");
    endtask
    task t_gain;
        logic signed [7:0] v [6] = '{-8'sd90, -8'sd80, -8'sd70, -8'sd60, -8'sd50, -8'sd49};
        logic [2:0] g [6] = '{GAIN_G1, GAIN_G2, GAIN_G3, GAIN_G4, GAIN_G5, GAIN_G6};
        for (int i = 0; i < 6; i++) begin
            lvl(v[i]);
            chk(front_gain_step, g[i]);
        end
        $display("gain test done");
    endtask
    task t_cal;
        level_in <= -8'sd60;
        wr(ADDR_CTRL, 32'h0a);
        @(posedge pclk);
        chk(cal_busy, 1'b1);
        lvl(-8'sd60);
        chk(front_gain_step, GAIN_G6);
        for (int i = 0; i < 20 && cal_busy !== 1'b0; i++) @(posedge pclk);
        chk(cal_busy, 1'b0);
        $display("calibration test done");
    endtask
    task t_level;
        wr(ADDR_LVLCFG, 32'h78);
        repeat (2) lvl(-8'sd40);
        @(posedge pclk);
        rdc(ADDR_LEVEL, 32'h5f);
        wr(ADDR_LVLCFG, 32'h81);
        repeat (4) lvl(-8'sd40);
        lvl(-8'sd60);
        @(posedge pclk);
        rdc(ADDR_LEVEL, 32'h4a);
        $display("level test done");
    endtask
    task t_rx;
        wr(ADDR_DETTH, 32'h0);
        wr(ADDR_CTRL, 32'h28);
        repeat (4) @(posedge pclk);
        chk(rx_active, 1'b0);
        preamble_ok <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(rx_active, 1'b1);
        bb_sample <= 8'sd40;
        bb_valid <= 1'b1;
        @(posedge pclk);
        bb_valid <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
        chk(rx_data_valid, 1'b1);
        preamble_ok <= 1'b0;
        done_ev <= 1'b1;
        @(posedge pclk);
        done_ev <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(rx_active, 1'b0);
        $display("receive state test done");
    endtask
    task t_spread;
        wr(ADDR_CTRL, 32'h2c);
        acc = 0;
        hdr_ev <= 1'b1;
        @(posedge pclk);
        hdr_ev <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            pulse_ss(8'h40);
            acc = acc - acc / 8 + 64;
        end
        rdc(ADDR_LIVE, 32'h40);
        done_ev <= 1'b1;
        @(posedge pclk);
        done_ev <= 1'b0;
        repeat (2) @(posedge pclk);
        rdc(ADDR_FRAME, 32'(acc / 8));
        $display("spread test done");
    endtask
    task t_therm;
        therm_adc <= 8'h5a;
        wr(ADDR_CTRL, 32'h20);
        repeat (45) @(posedge pclk);
        chk(sensor_enable, 1'b1);
        wr(ADDR_CTRL, 32'h21);
        @(posedge pclk);
        chk(sensor_enable, 1'b0);
        wr(ADDR_CTRL, 32'h08);
        rdc(ADDR_THERM, 32'h5a);
        $display("thermal test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        bad_count++;
        end_sim;
    end
    initial begin
        presetn = 1'b0;
        {level_in, level_valid, bb_sample, bb_valid, preamble_ok, hdr_ev, done_ev} = '0;
        {ss_level, ss_valid, therm_adc} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_filt;
        t_gain;
        t_cal;
        t_level;
        t_rx;
        t_spread;
        t_therm;
        end_sim;
    end
endmodule
`default_nettype wire
